// [core/pwt_top.sv]
// pwm timers (one 24-bit, four 16-bit) and watchdog with register port
// Functional notes
// - 24-bit counter behind 8-bit prescaler
// - 24-bit timer has two compare registers
// - compare writes buffered while running, loaded after match
// - capture edge selectable rise, fall, both
// - capture copies counter into capture register
// - 24-bit clear on wrap, compare, software
// - five separately enabled 24-bit interrupt sources
// - second compare match drives configured pin action
// - first 24-bit compare drives no pin action
// - pin level readable, pin usable as input
// - four 16-bit counters, own prescalers
// - 16-bit compares buffered while running, loaded after match
// - 16-bit clear on wrap, compare, software
// - 16-bit overflow, compare interrupts separately enabled
// - 16-bit compare match drives pin action
// - watchdog on slow oscillator resets on expiry
// - key write restarts the watchdog count
// - watchdog enable sticks until device reset
// - half timeout flag readable by software
//
// Implementation choices: strobed register access and the address map.
module pwt_top
    import pwt_pkg::*;
#(
    parameter int WD_TIMEOUT = 65536
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire pwt_bus_t bus,
    output logic [31:0] rdata,
    input wire logic [1:0] cap_in,
    input wire logic [NT-1:0] pin_in,
    output logic [NT-1:0] pin_out,
    output logic [NT-1:0] pin_oe,
    output logic [NT-1:0] irq,
    input wire logic wd_osc,
    output logic wd_rst
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic hit(input logic [AW-1:0] a, input int b,
                                 input logic [2:0] r);
        hit = a[7:5] == 3'(b) && a[4:2] == r;
    endfunction : hit
    function automatic logic [23:0] tmax(input int i);
        tmax = (i == 0) ? MAX24 : MAX16;
    endfunction : tmax
    function automatic logic pin_act(input logic [1:0] act, input logic p);
        case (act)
            ACT_SET: pin_act = 1'b1;
            ACT_CLR: pin_act = 1'b0;
            ACT_TGL: pin_act = ~p;
            default: pin_act = p;
        endcase
    endfunction : pin_act
    function automatic logic edge_hit(input logic [1:0] m, input logic q,
                                      input logic d);
        case (m)
            EDG_RISE: edge_hit = !q && d;
            EDG_FALL: edge_hit = q && !d;
            EDG_BOTH: edge_hit = q != d;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // ************************************************************
    // state
    // ************************************************************
    logic [31:0] ctrl [NT];
    logic [7:0] pre [NT];
    logic [23:0] cnt [NT];
    logic [23:0] buf0 [NT];
    logic [23:0] buf1 [NT];
    logic [23:0] act0 [NT];
    logic [23:0] act1 [NT];
    logic [NT-1:0] pend0;
    logic [NT-1:0] pend1;
    logic [NSRC-1:0] stat [NT];
    logic [23:0] cap0;
    logic [23:0] cap1;
    logic [1:0] cap_q;
    logic [NT-1:0] tick;
    logic [NT-1:0] wrap;
    logic [NT-1:0] m0;
    logic [NT-1:0] m1;
    logic [NT-1:0] swr;
    logic [NT-1:0] clr_cnt;
    logic [1:0] cap_ev;
    logic [31:0] next_rdata;

    always_comb begin
        for (int i = 0; i < NT; i++) begin
            tick[i] = ctrl[i][F_RUN] && pre[i] == ctrl[i][F_PRE+:8];
            wrap[i] = tick[i] && cnt[i] == tmax(i);
            m0[i] = tick[i] && cnt[i] == act0[i];
            m1[i] = tick[i] && cnt[i] == act1[i];
            swr[i] = bus.wr && hit(bus.addr, i, R_CTRL) && bus.wdata[F_SWRST];
            case (ctrl[i][F_RSRC+:2])
                RS_CMP0: clr_cnt[i] = m0[i];
                RS_CMP1: clr_cnt[i] = m1[i];
                default: clr_cnt[i] = wrap[i];
            endcase
        end
        cap_ev[0] = edge_hit(ctrl[0][F_EDG0+:2], cap_q[0], cap_in[0]);
        cap_ev[1] = edge_hit(ctrl[0][F_EDG1+:2], cap_q[1], cap_in[1]);
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl <= '{default: CTRL_RST};
        end else begin
            for (int i = 0; i < NT; i++) begin
                if (bus.wr && hit(bus.addr, i, R_CTRL)) begin
                    ctrl[i] <= bus.wdata & CTRL_MASK;
                end
            end
        end
    end

    // ************************************************************
    // prescalers and counters
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre <= '{default: 8'h00};
            cnt <= '{default: 24'h000000};
        end else begin
            for (int i = 0; i < NT; i++) begin
                if (swr[i]) begin
                    pre[i] <= 8'h00;
                    cnt[i] <= 24'h000000;
                end else if (tick[i]) begin
                    pre[i] <= 8'h00;
                    if (clr_cnt[i] || wrap[i]) begin
                        cnt[i] <= 24'h000000;
                    end else begin
                        cnt[i] <= cnt[i] + 24'h000001;
                    end
                end else if (ctrl[i][F_RUN]) begin
                    pre[i] <= pre[i] + 8'h01;
                end
            end
        end
    end

    // ************************************************************
    // compare shadow buffers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            buf0 <= '{default: 24'h000000};
            buf1 <= '{default: 24'h000000};
            act0 <= '{default: 24'h000000};
            act1 <= '{default: 24'h000000};
            pend0 <= '0;
            pend1 <= '0;
        end else begin
            for (int i = 0; i < NT; i++) begin
                if (m0[i] && pend0[i]) begin
                    act0[i] <= buf0[i];
                    pend0[i] <= 1'b0;
                end
                if (m1[i] && pend1[i]) begin
                    act1[i] <= buf1[i];
                    pend1[i] <= 1'b0;
                end
                if (bus.wr && hit(bus.addr, i, R_CMP0)) begin
                    buf0[i] <= bus.wdata[23:0] & tmax(i);
                    if (ctrl[i][F_RUN]) begin
                        pend0[i] <= 1'b1;
                    end else begin
                        act0[i] <= bus.wdata[23:0] & tmax(i);
                    end
                end
                if (bus.wr && hit(bus.addr, i, R_CMP1)) begin
                    buf1[i] <= bus.wdata[23:0] & tmax(i);
                    if (ctrl[i][F_RUN]) begin
                        pend1[i] <= 1'b1;
                    end else begin
                        act1[i] <= bus.wdata[23:0] & tmax(i);
                    end
                end
            end
        end
    end

    // ************************************************************
    // capture inputs (long timer only)
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cap_q <= 2'b00;
            cap0 <= 24'h000000;
            cap1 <= 24'h000000;
        end else begin
            cap_q <= cap_in;
            if (cap_ev[0]) begin
                cap0 <= cnt[0];
            end
            if (cap_ev[1]) begin
                cap1 <= cnt[0];
            end
        end
    end

    // ************************************************************
    // event flags and interrupt requests; a set beats a clear
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stat <= '{default: '0};
            irq <= '0;
        end else begin
            for (int i = 0; i < NT; i++) begin
                logic [NSRC-1:0] set;
                logic [NSRC-1:0] clr;
                set = '0;
                clr = '0;
                set[S_OVF] = wrap[i];
                set[S_CMP0] = m0[i];
                set[S_CMP1] = m1[i];
                if (i == 0) begin
                    set[S_CAP0] = cap_ev[0];
                    set[S_CAP1] = cap_ev[1];
                end
                if (bus.wr && hit(bus.addr, i, R_STAT)) begin
                    clr = bus.wdata[NSRC-1:0];
                end
                stat[i] <= (stat[i] & ~clr) | set;
                irq[i] <= |(stat[i] & ctrl[i][F_IEN+:NSRC]);
            end
        end
    end

    // ************************************************************
    // output pins
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            for (int i = 0; i < NT; i++) begin
                logic p;
                p = pin_out[i];
                if (i != 0 && m0[i]) begin
                    p = pin_act(ctrl[i][F_ACT0+:2], p);
                end
                if (m1[i]) begin
                    p = pin_act(ctrl[i][F_ACT1+:2], p);
                end
                pin_out[i] <= p;
                pin_oe[i] <= !ctrl[i][F_GPIO];
            end
        end
    end

    // ************************************************************
    // watchdog, counted on slow oscillator rising edges
    // ************************************************************
    pwt_wd_state_t wd_st;
    logic wd_osc_q;
    logic [31:0] wd_cnt;
    logic wd_half;
    logic wd_edge;
    logic wd_kick;
    assign wd_edge = wd_osc && !wd_osc_q;
    assign wd_kick = bus.wr && hit(bus.addr, WD_BLK, R_WDKEY)
                     && bus.wdata[W_KEY];
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wd_st <= WD_OFF;
        end else begin
            case (wd_st)
                WD_OFF: begin
                    if (bus.wr && hit(bus.addr, WD_BLK, R_WDCTRL)
                        && bus.wdata[W_EN]) begin
                        wd_st <= WD_ON;
                    end
                end
                WD_ON: wd_st <= WD_ON;
                default: wd_st <= WD_OFF;
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wd_osc_q <= 1'b0;
            wd_cnt <= 32'h00000000;
            wd_half <= 1'b0;
            wd_rst <= 1'b0;
        end else begin
            wd_osc_q <= wd_osc;
            wd_rst <= 1'b0;
            if (wd_kick || wd_st == WD_OFF) begin
                wd_cnt <= 32'h00000000;
                wd_half <= 1'b0;
            end else if (wd_edge) begin
                if (wd_cnt == 32'(WD_TIMEOUT - 1)) begin
                    wd_cnt <= 32'h00000000;
                    wd_half <= 1'b0;
                    wd_rst <= 1'b1;
                end else begin
                    wd_cnt <= wd_cnt + 32'h00000001;
                    if (wd_cnt + 32'h00000001 == 32'(WD_TIMEOUT / 2)) begin
                        wd_half <= 1'b1;
                    end
                end
            end
        end
    end

    // ************************************************************
    // register read port
    // ************************************************************
    always_comb begin
        next_rdata = 32'h00000000;
        for (int i = 0; i < NT; i++) begin
            if (bus.addr[7:5] == 3'(i)) begin
                case (bus.addr[4:2])
                    R_CTRL: next_rdata = ctrl[i];
                    R_CMP0: next_rdata = {8'h00, buf0[i]};
                    R_CMP1: next_rdata = {8'h00, buf1[i]};
                    R_CNT: next_rdata = {8'h00, cnt[i]};
                    R_STAT: begin
                        next_rdata[NSRC-1:0] = stat[i];
                        next_rdata[S_PIN] = ctrl[i][F_GPIO] ? pin_in[i]
                                            : pin_out[i];
                    end
                    R_CAP0: next_rdata = (i == 0) ? {8'h00, cap0} : 32'h0;
                    R_CAP1: next_rdata = (i == 0) ? {8'h00, cap1} : 32'h0;
                    default: next_rdata = 32'h00000000;
                endcase
            end
        end
        if (bus.addr[7:5] == WD_BLK && bus.addr[4:2] == R_WDCTRL) begin
            next_rdata[W_EN] = wd_st == WD_ON;
            next_rdata[W_HALF] = wd_half;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= bus.rd ? next_rdata : 32'h00000000;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_adv0;
        tick[0] && !swr[0] && !clr_cnt[0] && !wrap[0];
    endsequence
    sequence s_load1;
        m1[0] && pend1[0] && !(bus.wr && hit(bus.addr, 0, R_CMP1));
    endsequence
    a_long_advance: assert property (
        s_adv0 |=> cnt[0] == $past(cnt[0]) + 24'h1)
        else $error("long counter did not advance");
    a_shadow_load: assert property (
        s_load1 |=> act1[0] == $past(buf1[0]))
        else $error("buffered compare not loaded on match");
    a_shadow_hold: assert property (ctrl[1][F_RUN] && !m1[1]
        && bus.wr && hit(bus.addr, 1, R_CMP1) |=> act1[1] == $past(act1[1]))
        else $error("compare changed before match");
    a_capture_copy: assert property (cap_ev[0] |=> cap0 == $past(cnt[0]))
        else $error("capture value wrong");
    a_cmp0_no_pin: assert property (m0[0] && !m1[0]
        |=> pin_out[0] == $past(pin_out[0]))
        else $error("first compare touched long pin");
    a_soft_clear: assert property (swr[1]
        |=> cnt[1] == 24'h0 && pre[1] == 8'h00)
        else $error("software clear failed");
    a_wrap_flag: assert property (wrap[1]
        |=> stat[1][S_OVF] && cnt[1] == 24'h0)
        else $error("overflow not flagged");
    a_wd_sticky: assert property (wd_st == WD_ON
        |=> wd_st == WD_ON [*2])
        else $error("watchdog disabled by firmware");
    a_wd_restart: assert property (wd_kick
        |=> wd_cnt == 32'h0 && !wd_rst)
        else $error("watchdog not restarted by key");
    a_wd_half: assert property (wd_st == WD_ON && !wd_kick && wd_edge
        && wd_cnt + 32'h1 == 32'(WD_TIMEOUT / 2) |=> wd_half)
        else $error("half flag missing");

endmodule : pwt_top

// [include/pwt_pkg.sv]
// constants and types of the pwm timer and watchdog unit
package pwt_pkg;

    // ************************************************************
    // register map: addr[7:5] picks a timer block or the watchdog block, addr[4:2] a word
    // ************************************************************
    localparam int NT = 5;
    localparam int AW = 8;
    localparam logic [2:0] R_CTRL = 3'h0;
    localparam logic [2:0] R_CMP0 = 3'h1;
    localparam logic [2:0] R_CMP1 = 3'h2;
    localparam logic [2:0] R_CNT = 3'h3;
    localparam logic [2:0] R_STAT = 3'h4;
    localparam logic [2:0] R_CAP0 = 3'h5;
    localparam logic [2:0] R_CAP1 = 3'h6;
    localparam logic [2:0] WD_BLK = 3'h5;
    localparam logic [2:0] R_WDCTRL = 3'h0;
    localparam logic [2:0] R_WDKEY = 3'h1;

    // ************************************************************
    // control word fields
    // ************************************************************
    localparam int F_PRE = 0;
    localparam int F_RUN = 8;
    localparam int F_RSRC = 9;
    localparam int F_SWRST = 11;
    localparam int F_IEN = 12;
    localparam int F_ACT0 = 17;
    localparam int F_ACT1 = 19;
    localparam int F_GPIO = 21;
    localparam int F_EDG0 = 22;
    localparam int F_EDG1 = 24;
    localparam logic [31:0] CTRL_MASK = 32'h03fff7ff;
    localparam logic [31:0] CTRL_RST = 32'h00000000;

    // status word bits
    localparam int S_OVF = 0;
    localparam int S_CMP0 = 1;
    localparam int S_CMP1 = 2;
    localparam int S_CAP0 = 3;
    localparam int S_CAP1 = 4;
    localparam int S_PIN = 8;
    localparam int NSRC = 5;

    // watchdog control bits
    localparam int W_EN = 0;
    localparam int W_HALF = 1;
    localparam int W_KEY = 0;

    localparam logic [23:0] MAX24 = 24'hffffff;
    localparam logic [23:0] MAX16 = 24'h00ffff;

    // ************************************************************
    // encodings
    // ************************************************************
    localparam logic [1:0] RS_WRAP = 2'h0;
    localparam logic [1:0] RS_CMP0 = 2'h1;
    localparam logic [1:0] RS_CMP1 = 2'h2;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_SET = 2'h1;
    localparam logic [1:0] ACT_CLR = 2'h2;
    localparam logic [1:0] ACT_TGL = 2'h3;
    localparam logic [1:0] EDG_OFF = 2'h0;
    localparam logic [1:0] EDG_RISE = 2'h1;
    localparam logic [1:0] EDG_FALL = 2'h2;
    localparam logic [1:0] EDG_BOTH = 2'h3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [AW-1:0] addr;
        logic [31:0] wdata;
    } pwt_bus_t;

    typedef enum logic {WD_OFF, WD_ON} pwt_wd_state_t;

endpackage : pwt_pkg

// [tb/pwt_top_tb.sv]
// self-checking bench of the pwm timer and watchdog unit
`define CHK(g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("[ERR] %0t got %h exp %h", $time, g, e); \
        end \
    end

module pwt_top_tb
    import pwt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // bench signals
    // ********************************
    localparam int WDT = 8;
    localparam logic [7:0] WDA = {WD_BLK, R_WDCTRL, 2'h0};
    localparam logic [7:0] WDK = {WD_BLK, R_WDKEY, 2'h0};
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    pwt_bus_t bus = '0;
    logic [31:0] rdata;
    logic [1:0] cap_in = 2'h0;
    logic [NT-1:0] pin_in = '0;
    logic [NT-1:0] pin_out;
    logic [NT-1:0] pin_oe;
    logic [NT-1:0] irq;
    logic wd_osc = 1'b0;
    logic wd_rst;
    logic [31:0] lfsr = 32'h00013e47;
    logic [31:0] d;
    int bad_count = 0;
    int n_tests = 0;
    int rst_seen = 0;

    always #10 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (wd_rst === 1'b1) begin
            rst_seen++;
        end
    end

    pwt_top #(.WD_TIMEOUT(WDT)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .bus(bus), .rdata(rdata),
        .cap_in(cap_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .irq(irq), .wd_osc(wd_osc), .wd_rst(wd_rst)
    );

    // ********************************
    // helpers and bus tasks
    // ********************************
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    function automatic logic [7:0] ad(input int t, input int r);
        return {t[2:0], r[2:0], 2'h0};
    endfunction : ad

    function automatic logic [31:0] ctl(input int p, input int rs,
        input int ien, input int a0, input int a1);
        return 32'(p) | 32'h100 | 32'(rs) << F_RSRC | 32'(ien) << F_IEN
            | 32'(a0) << F_ACT0 | 32'(a1) << F_ACT1;
    endfunction : ctl

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk_sys);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk_sys);
        bus <= '0;
        #1 d = rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(d, e);
    endtask : rchk

    // cycles between two changes of a pin, 0 when it stays quiet
    task automatic gap(input int t, output int n);
        logic p;
        int k;
        n = 0;
        @(posedge clk_sys);
        p = pin_out[t];
        for (k = 0; k < 300 && pin_out[t] === p; k++) begin
            @(posedge clk_sys);
        end
        if (k < 300) begin
            p = pin_out[t];
            for (k = 1; k < 300 && n == 0; k++) begin
                @(posedge clk_sys);
                if (pin_out[t] !== p) begin
                    n = k;
                end
            end
        end
    endtask : gap

    task automatic pulse(input int i, input logic lvl);
        @(posedge clk_sys);
        cap_in[i] <= lvl;
        cyc(4);
        rd(ad(0, R_STAT));
    endtask : pulse

    task automatic osc(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            wd_osc <= 1'b1;
            cyc(4);
            wd_osc <= 1'b0;
            cyc(3);
        end
    endtask : osc

    task automatic tally_and_finish();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // ********************************
    // scenarios
    // ********************************
    initial begin : main
        int t;
        int p;
        int c;
        int n;
        int m;
        int i;
        logic [31:0] v;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        cyc(2);
        `CHK(pin_oe, 5'h1f);
        `CHK(pin_out, 5'h00);
        for (t = 0; t < NT; t++) begin
            rchk(ad(t, R_CTRL), CTRL_RST);
        end
        rchk(WDA, 32'h0);
        for (t = 0; t < NT; t++) begin
            p = int'(rnd() % 4);
            c = 3 + int'(rnd() % 8);
            wr(ad(t, R_CMP0), 32'(c));
            wr(ad(t, R_CMP1), 32'(c));
            wr(ad(t, R_CTRL), ctl(p, RS_CMP1, 4, ACT_NONE, ACT_TGL));
            gap(t, n);
            gap(t, n);
            `CHK(n, (c + 1) * (p + 1));
            `CHK(irq[t], 1'b1);
            wr(ad(t, R_CMP1), 32'(c + 2));
            rchk(ad(t, R_CMP1), 32'(c + 2));
            gap(t, n);
            gap(t, n);
            `CHK(n, (c + 3) * (p + 1));
            // soft clear too: the count may already sit past compare 0
            wr(ad(t, R_CTRL), ctl(p, RS_CMP0, 2, ACT_TGL, ACT_NONE)
                | 32'h1 << F_SWRST);
            gap(t, n);
            gap(t, n);
            `CHK(n, t == 0 ? 0 : (c + 1) * (p + 1));
            wr(ad(t, R_CTRL), 32'h7 << F_IEN);
            rd(ad(t, R_STAT));
            `CHK(d[2:1], 2'h3);
            wr(ad(t, R_STAT), 32'h1f);
            cyc(2);
            `CHK(irq[t], 1'b0);
        end
        wr(ad(1, R_CTRL), ctl(0, RS_WRAP, 1, ACT_NONE, ACT_NONE)
            | 32'h1 << F_SWRST);
        cyc(65530);
        rd(ad(1, R_STAT));
        `CHK(d[S_OVF], 1'b0);
        cyc(12);
        rd(ad(1, R_STAT));
        `CHK(d[S_OVF], 1'b1);
        `CHK(irq[1], 1'b1);
        cyc(40);
        wr(ad(1, R_CTRL), 32'h1900);
        rd(ad(1, R_CNT));
        `CHK(d, 32'h1);
        rchk(ad(1, R_CTRL), 32'h1100);
        wr(ad(0, R_CTRL), ctl(0, RS_WRAP, 0, ACT_NONE, ACT_NONE));
        cyc(5 + int'(rnd() % 50));
        wr(ad(0, R_CTRL), 32'h0);
        rd(ad(0, R_CNT));
        v = d;
        for (i = 0; i < 2; i++) begin
            for (m = 1; m < 4; m++) begin
                wr(ad(0, R_CTRL), 32'(m) << (F_EDG0 + 2 * i)
                    | 32'h1 << (F_IEN + 3 + i));
                wr(ad(0, R_STAT), 32'h1f);
                pulse(i, 1'b1);
                `CHK(d[S_CAP0 + i], 1'(m & 1));
                `CHK(irq[0], 1'(m & 1));
                wr(ad(0, R_STAT), 32'h1f);
                pulse(i, 1'b0);
                `CHK(d[S_CAP0 + i], 1'(m >> 1));
                rchk(ad(0, R_CAP0 + i), v);
            end
        end
        for (t = 0; t < NT; t++) begin
            wr(ad(t, R_CTRL), 32'h1 << F_GPIO);
            v = rnd();
            pin_in <= v[NT-1:0];
            cyc(3);
            `CHK(pin_oe[t], 1'b0);
            rd(ad(t, R_STAT));
            `CHK(d[S_PIN], pin_in[t]);
        end
        osc(10);
        `CHK(rst_seen, 0);
        wr(WDA, 32'h1);
        osc(3);
        rchk(WDA, 32'h1);
        osc(1);
        rchk(WDA, 32'h3);
        wr(WDK, 32'h1);
        rchk(WDA, 32'h1);
        osc(7);
        `CHK(rst_seen, 0);
        osc(1);
        `CHK(rst_seen, 1);
        wr(WDA, 32'h0);
        rchk(WDA, 32'h1);
        cyc(1);
        nrst <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        cyc(1);
        rchk(WDA, 32'h0);
        tally_and_finish();
    end

    initial begin : watchdog
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        tally_and_finish();
    end

endmodule : pwt_top_tb
